// [src/ips_defs.svh]
`ifndef IPS_DEFS_SVH
`define IPS_DEFS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define IPS_CLK_KHZ      10000
`define IPS_HOLD_MS      220
`define IPS_TEST_MS      30
`define IPS_RETRY_MS     2000
`define IPS_HOLD_CYC     (`IPS_HOLD_MS * `IPS_CLK_KHZ)
`define IPS_TEST_CYC     (`IPS_TEST_MS * `IPS_CLK_KHZ)
`define IPS_RETRY_CYC    (`IPS_RETRY_MS * `IPS_CLK_KHZ)

// ==========================================================================
// Register offsets
// ==========================================================================
`define IPS_OFS_CTRL     12'h000
`define IPS_OFS_LIMIT    12'h004
`define IPS_OFS_DRIVE    12'h008
`define IPS_OFS_STATUS   12'h00C

// ==========================================================================
// Field positions
// ==========================================================================
`define IPS_CTRL_KICK    0
`define IPS_CTRL_FDET    1
`define IPS_CTRL_BSWOFF  2
`define IPS_CTRL_CHGEN   3
`define IPS_CTRL_PSDIS   4
`define IPS_LIM_IIN      0
`define IPS_LIM_VLIM     8
`define IPS_LIM_VOS      12
`define IPS_LIM_TRK      16
`define IPS_DRV_DP       0
`define IPS_DRV_DM       2
`define IPS_ST_INGOOD    0
`define IPS_ST_PGOOD     1
`define IPS_ST_TYPE      2
`define IPS_ST_FSM       8

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define IPS_IIN_RST      5'h04
`define IPS_VLIM_RST     4'h0
`define IPS_IIN_200MA    5'h01
`define IPS_IIN_500MA    5'h04
`define IPS_IIN_1000MA   5'h09
`define IPS_IIN_2000MA   5'h13
`define IPS_IIN_2100MA   5'h14
`define IPS_IIN_2400MA   5'h17
`define IPS_TYPE_NONE    3'h0
`define IPS_TYPE_SDP     3'h1
`define IPS_TYPE_ADAPT   3'h2
`define IPS_TYPE_DCP     3'h3
`define IPS_TYPE_UNKNOWN 3'h5
`define IPS_WIN_V1P2     2'h1
`define IPS_WIN_V2P0     2'h2
`define IPS_WIN_V2P7     2'h3

`endif

// [src/ips_pkg.sv]
package ips_pkg;

    // ======================================================================
    // Sequencer states
    // ======================================================================
    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_HOLD   = 6'h02,
        ST_QUAL   = 6'h04,
        ST_RETRY  = 6'h08,
        ST_DETECT = 6'h10,
        ST_CONV   = 6'h20
    } ips_state_t;

    // ======================================================================
    // Analog comparator and pin inputs
    // ======================================================================
    typedef struct packed {
        logic       vac_present;
        logic       vac_above_bat;
        logic       vbus_ov;
        logic       vbus_above_min;
        logic       bat_above_depl;
        logic       bat_ocp;
        logic       ship_exit;
        logic       sys_below_2v2;
        logic       in_below_sleep;
        logic       bat_below_minsys;
        logic       psel;
        logic       dline_variant;
        logic       bc_done;
        logic       bc_is_sdp;
        logic       bc_is_dcp;
        logic       dcd_timeout;
        logic [1:0] dp_win;
        logic [1:0] dm_win;
    } ips_pins_t;

    // ======================================================================
    // Power stage controls
    // ======================================================================
    typedef struct packed {
        logic       comparators_armed;
        logic       internal_ldo;
        logic       battery_switch;
        logic       test_load;
        logic       converter_en;
        logic       pulse_skip_allow;
        logic       bc_detect_run;
        logic [4:0] iin_limit;
        logic [3:0] vin_limit;
        logic [1:0] vin_offset;
        logic       vin_track_en;
        logic [1:0] vin_track_offset;
        logic [1:0] dplus_drive_level;
        logic [1:0] dminus_drive_level;
    } ips_power_t;

    // ======================================================================
    // Whole module state
    // ======================================================================
    typedef struct packed {
        ips_pins_t  sync1;
        ips_pins_t  sync2;
        ips_state_t fsm;
        logic [24:0] cnt;
        logic       host_mode;
        logic       force_source_detect;
        logic       battery_switch_force_off;
        logic       charge_enable;
        logic       pulse_skip_disable;
        logic [4:0] input_current_limit_field;
        logic [3:0] input_voltage_limit_field;
        logic [1:0] input_voltage_offset_field;
        logic [1:0] battery_track_offset;
        logic [1:0] dplus_drive_level;
        logic [1:0] dminus_drive_level;
        logic       input_good_flag;
        logic       power_good_flag;
        logic [2:0] source_type_field;
        logic       alert_n;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
        ips_power_t pwr;
    } ips_state_s_t;

endpackage : ips_pkg

// [src/ips_sequencer.sv]
`timescale 1ns/1ns
`include "ips_defs.svh"
module ips_sequencer
    import ips_pkg::*;
#(
    parameter logic [24:0] HOLD_CYC  = 25'(`IPS_HOLD_CYC),
    parameter logic [24:0] TEST_CYC  = 25'(`IPS_TEST_CYC),
    parameter logic [24:0] RETRY_CYC = 25'(`IPS_RETRY_CYC)
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog and pin inputs, asynchronous
    input  wire ips_pins_t   pins,
    // Power stage controls
    output ips_power_t       pwr,
    // Host alert, active low one-cycle pulse
    output logic             host_alert_pin_n
);

    // ======================================================================
    // Decoding helpers
    // ======================================================================
    // Returns {type, limit} for a non-standard adapter from the line windows.
    function automatic logic [7:0] classify_nonstd(input logic [1:0] dp,
                                                   input logic [1:0] dm);
        logic [7:0] r;
        // Window pairs that match no divider read as unknown.
        r = {`IPS_TYPE_UNKNOWN, `IPS_IIN_500MA};
        if (dp == `IPS_WIN_V2P7 && dm == `IPS_WIN_V2P0) begin
            r = {`IPS_TYPE_ADAPT, `IPS_IIN_2100MA};
        end else if (dp == `IPS_WIN_V1P2 && dm == `IPS_WIN_V1P2) begin
            r = {`IPS_TYPE_ADAPT, `IPS_IIN_2000MA};
        end else if (dp == `IPS_WIN_V2P0 && dm == `IPS_WIN_V2P7) begin
            r = {`IPS_TYPE_ADAPT, `IPS_IIN_1000MA};
        end else if (dp == `IPS_WIN_V2P7 && dm == `IPS_WIN_V2P7) begin
            r = {`IPS_TYPE_ADAPT, `IPS_IIN_2400MA};
        end
        return r;
    endfunction : classify_nonstd

    // Returns {type, limit} from the select pin level.
    function automatic logic [7:0] classify_psel(input logic sel);
        logic [7:0] r;
        r = sel ? {`IPS_TYPE_SDP, `IPS_IIN_500MA}
                : {`IPS_TYPE_ADAPT, `IPS_IIN_2400MA};
        return r;
    endfunction : classify_psel

    // Returns {mapped, data} for a register read.
    function automatic logic [32:0] read_reg(input logic [11:0]  a,
                                             input ips_state_s_t s);
        logic [31:0] v;
        logic        hit;
        v   = 32'h0000_0000;
        hit = 1'b1;
        case (a)
            `IPS_OFS_CTRL: begin
                v[`IPS_CTRL_KICK]   = s.host_mode;
                v[`IPS_CTRL_FDET]   = s.force_source_detect;
                v[`IPS_CTRL_BSWOFF] = s.battery_switch_force_off;
                v[`IPS_CTRL_CHGEN]  = s.charge_enable;
                v[`IPS_CTRL_PSDIS]  = s.pulse_skip_disable;
            end
            `IPS_OFS_LIMIT: begin
                v[`IPS_LIM_IIN +: 5]  = s.input_current_limit_field;
                v[`IPS_LIM_VLIM +: 4] = s.input_voltage_limit_field;
                v[`IPS_LIM_VOS +: 2]  = s.input_voltage_offset_field;
                v[`IPS_LIM_TRK +: 2]  = s.battery_track_offset;
            end
            `IPS_OFS_DRIVE: begin
                v[`IPS_DRV_DP +: 2] = s.dplus_drive_level;
                v[`IPS_DRV_DM +: 2] = s.dminus_drive_level;
            end
            `IPS_OFS_STATUS: begin
                v[`IPS_ST_INGOOD]  = s.input_good_flag;
                v[`IPS_ST_PGOOD]   = s.power_good_flag;
                v[`IPS_ST_TYPE +: 3] = s.source_type_field;
                v[`IPS_ST_FSM +: 6]  = s.fsm;
            end
            default: begin
                // Holes read zero and raise the error flag.
                hit = 1'b0;
            end
        endcase
        return {hit, v};
    endfunction : read_reg

    // ======================================================================
    // State
    // ======================================================================
    ips_state_s_t q;
    ips_state_s_t d;

    always_comb begin
        ips_pins_t  p;
        logic       vac_ok;
        logic       done;
        logic [7:0] res;
        logic [32:0] rd;
        logic       wr;
        p      = q.sync2;
        vac_ok = 1'b0;
        done   = 1'b0;
        res    = 8'h00;
        rd     = 33'h0_0000_0000;
        wr     = 1'b0;
        d      = q;

        // Two-flop synchronisers; only the second stage is used below.
        d.sync1 = pins;
        d.sync2 = q.sync1;
        vac_ok  = p.vac_present & p.vac_above_bat;

        d.alert_n = 1'b1;
        // One shared timer; entry to ST_HOLD, ST_QUAL and ST_RETRY clears it.
        d.cnt     = q.cnt + 25'h000_0001;

        // ==================================================================
        // Power-up sequence
        // ==================================================================
        case (q.fsm)
            ST_OFF: begin
                d.cnt = 25'h000_0000;
                if (vac_ok) begin
                    d.fsm = ST_HOLD;
                    d.battery_switch_force_off = 1'b0;
                end
            end

            ST_HOLD: begin
                // Any drop of the input restarts the hold.
                if (!vac_ok) begin
                    d.fsm = ST_OFF;
                    d.cnt = 25'h000_0000;
                end else if (q.cnt == HOLD_CYC - 25'h000_0001) begin
                    d.fsm = ST_QUAL;
                    d.cnt = 25'h000_0000;
                end
            end

            ST_QUAL: begin
                // One bad sample fails the attempt.
                if (p.vbus_ov || !p.vbus_above_min) begin
                    d.fsm = ST_RETRY;
                    d.cnt = 25'h000_0000;
                end else if (q.cnt == TEST_CYC - 25'h000_0001) begin
                    d.fsm             = ST_DETECT;
                    d.cnt             = 25'h000_0000;
                    d.input_good_flag = 1'b1;
                    d.alert_n         = 1'b0;
                end
            end

            ST_RETRY: begin
                // The load is off between attempts.
                if (q.cnt == RETRY_CYC - 25'h000_0001) begin
                    d.fsm = ST_QUAL;
                    d.cnt = 25'h000_0000;
                end
            end

            ST_DETECT: begin
                // The contact timeout outranks classification.
                if (!p.dline_variant) begin
                    done = 1'b1;
                    res  = classify_psel(p.psel);
                end else if (p.dcd_timeout) begin
                    done = 1'b1;
                    res  = classify_nonstd(p.dp_win, p.dm_win);
                end else if (p.bc_done) begin
                    done = 1'b1;
                    if (p.bc_is_dcp) begin
                        res = {`IPS_TYPE_DCP, `IPS_IIN_2400MA};
                    end else if (p.bc_is_sdp) begin
                        res = {`IPS_TYPE_SDP, `IPS_IIN_500MA};
                    end else begin
                        res = {`IPS_TYPE_UNKNOWN, `IPS_IIN_500MA};
                    end
                end
                // Keep the two alert pulses apart.
                if (!q.alert_n) begin
                    done = 1'b0;
                end
                if (done) begin
                    d.fsm                       = ST_CONV;
                    d.alert_n                   = 1'b0;
                    d.input_current_limit_field = res[4:0];
                    d.power_good_flag           = 1'b1;
                    d.source_type_field         = res[7:5];
                    d.force_source_detect       = 1'b0;
                end
            end

            ST_CONV: begin
                // In host mode the result stands until asked.
                if (q.host_mode && q.force_source_detect) begin
                    d.fsm = ST_DETECT;
                end else if (!q.host_mode && !p.dline_variant) begin
                    // Default mode follows the select pin in real time.
                    res = classify_psel(p.psel);
                    d.input_current_limit_field = res[4:0];
                    d.source_type_field         = res[7:5];
                end
            end

            default: begin
                d.fsm = ST_OFF;
            end
        endcase

        // Losing the input drops the whole sequence back to the start.
        if (!p.vac_present && q.fsm != ST_OFF) begin
            d.fsm               = ST_OFF;
            d.input_good_flag   = 1'b0;
            d.power_good_flag   = 1'b0;
            d.source_type_field = `IPS_TYPE_NONE;
        end

        // ==================================================================
        // APB slave
        // ==================================================================
        // Read data and the error flag are prepared in the setup cycle so
        // that every access completes in its first access cycle.
        d.pready = 1'b1;
        if (psel && !penable) begin
            rd        = read_reg(paddr, q);
            d.prdata  = rd[31:0];
            d.pslverr = ~rd[32];
        end

        // Writes to holes or the status word are dropped.
        wr = psel & penable & pwrite & q.pready & ~q.pslverr;
        if (wr) begin
            case (paddr)
                `IPS_OFS_CTRL: begin
                    if (pwdata[`IPS_CTRL_KICK]) begin
                        d.host_mode = 1'b1;
                    end
                    // A host write of one outranks the hardware clear.
                    if (q.host_mode && pwdata[`IPS_CTRL_FDET]) begin
                        d.force_source_detect = 1'b1;
                    end
                    d.battery_switch_force_off = pwdata[`IPS_CTRL_BSWOFF];
                    d.charge_enable            = pwdata[`IPS_CTRL_CHGEN];
                    d.pulse_skip_disable       = pwdata[`IPS_CTRL_PSDIS];
                end
                `IPS_OFS_LIMIT: begin
                    d.input_current_limit_field  = pwdata[`IPS_LIM_IIN +: 5];
                    d.input_voltage_limit_field  = pwdata[`IPS_LIM_VLIM +: 4];
                    d.input_voltage_offset_field = pwdata[`IPS_LIM_VOS +: 2];
                    d.battery_track_offset       = pwdata[`IPS_LIM_TRK +: 2];
                end
                `IPS_OFS_DRIVE: begin
                    d.dplus_drive_level  = pwdata[`IPS_DRV_DP +: 2];
                    d.dminus_drive_level = pwdata[`IPS_DRV_DM +: 2];
                end
                default: begin
                    d.pslverr = q.pslverr;
                end
            endcase
        end


        // Overcurrent comes last so that it beats a software clear.
        if (p.bat_ocp && q.pwr.battery_switch) begin
            d.battery_switch_force_off = 1'b1;
        end else if (p.ship_exit) begin
            d.battery_switch_force_off = 1'b0;
        end

        // ==================================================================
        // Power stage outputs
        // ==================================================================
        // Armed from the first edge after reset.
        d.pwr.comparators_armed = 1'b1;
        d.pwr.internal_ldo      = d.fsm != ST_OFF && d.fsm != ST_HOLD;
        d.pwr.test_load         = d.fsm == ST_QUAL;
        d.pwr.bc_detect_run     = d.fsm == ST_DETECT && p.dline_variant;
        // Switching stops while the input sits below battery plus sleep.
        d.pwr.converter_en = d.fsm == ST_CONV && !p.in_below_sleep;
        // Force-off outranks every other request.
        if (d.battery_switch_force_off) begin
            d.pwr.battery_switch = 1'b0;
        end else if (d.fsm == ST_CONV) begin
            d.pwr.battery_switch = d.charge_enable;
        end else begin
            d.pwr.battery_switch = p.bat_above_depl;
        end
        d.pwr.pulse_skip_allow = d.pwr.converter_en && !d.pulse_skip_disable
                                 && (!d.charge_enable || p.bat_below_minsys);
        // A low system rail folds the limit down.
        d.pwr.iin_limit = d.input_current_limit_field;
        if (p.sys_below_2v2 && d.input_current_limit_field > `IPS_IIN_200MA) begin
            d.pwr.iin_limit = `IPS_IIN_200MA;
        end
        d.pwr.vin_limit        = d.input_voltage_limit_field;
        d.pwr.vin_offset       = d.input_voltage_offset_field;
        d.pwr.vin_track_offset = d.battery_track_offset;
        d.pwr.vin_track_en     = d.battery_track_offset != 2'h0
                                 && d.input_voltage_offset_field == 2'h0;
        // Line drivers are released while classification owns the lines.
        if (d.pwr.bc_detect_run) begin
            d.pwr.dplus_drive_level  = 2'h0;
            d.pwr.dminus_drive_level = 2'h0;
        end else begin
            d.pwr.dplus_drive_level  = d.dplus_drive_level;
            d.pwr.dminus_drive_level = d.dminus_drive_level;
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Non-zero defaults follow the clear.
            q                            <= '0;
            q.fsm                        <= ST_OFF;
            q.charge_enable              <= 1'b1;
            q.input_current_limit_field  <= `IPS_IIN_RST;
            q.input_voltage_limit_field  <= `IPS_VLIM_RST;
            q.alert_n                    <= 1'b1;
            q.pwr.iin_limit              <= `IPS_IIN_RST;
            q.pwr.vin_limit              <= `IPS_VLIM_RST;
        end else begin
            q <= d;
        end
    end

    // Every output comes straight from a flop.
    assign prdata           = q.prdata;
    assign pready           = q.pready;
    assign pslverr          = q.pslverr;
    assign pwr              = q.pwr;
    assign host_alert_pin_n = q.alert_n;

endmodule : ips_sequencer

// [tb/input_powerup_sequencer_bench.sv]
`timescale 1ns/1ns
module input_powerup_sequencer_bench;
    import ips_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, alert_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic        plugged, bad, sel_hi, ocp, sys_low;
    ips_pins_t   pins;
    ips_power_t  pwr;
    int          n_fail, n_tests, n_alert, cyc;

    ips_src_model src_u (.plugged(plugged), .bad(bad), .sel_hi(sel_hi), .ocp(ocp),
        .sys_low(sys_low), .pins(pins));
    ips_sequencer #(.HOLD_CYC(25'h14), .TEST_CYC(25'h0A), .RETRY_CYC(25'h1E)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .pwr(pwr), .host_alert_pin_n(alert_n));

    // ==================================================
    // Tasks
    // ==================================================
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string w, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(w, exp, d);
    endtask : rd
    task automatic wait_conv(input int lim);
        repeat (lim) begin
            if (pwr.converter_en === 1'b1) break;
            @(posedge pclk);
        end
        chk("converter on", 32'h1, 32'(pwr.converter_en));
    endtask : wait_conv
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // ==================================================
    // Clock, watchdog and stimulus
    // ==================================================
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (alert_n === 1'b0) n_alert++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, plugged, bad, ocp, sys_low} = 8'h00;
        sel_hi = 1'b1;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl reset", 12'h000, 32'h8);
        rd("limit reset", 12'h004, 32'h4);
        rd("status reset", 12'h00C, 32'h100);
        rd("unmapped", 12'h010, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        chk("battery only", 32'h1, 32'(pwr.battery_switch));
        n_alert = 0;
        plugged <= 1'b1;
        repeat (15) @(posedge pclk);
        chk("ldo early", 32'h0, 32'(pwr.internal_ldo));
        wait_conv(60);
        @(posedge pclk);
        chk("alert pulses", 32'h2, n_alert);
        rd("status sdp", 12'h00C, 32'h2007);
        rd("limit sdp", 12'h004, 32'h4);
        sel_hi <= 1'b0;
        repeat (6) @(posedge pclk);
        rd("limit adapter", 12'h004, 32'h17);
        rd("status adapter", 12'h00C, 32'h200B);
        apb(1'b1, 12'h000, 32'h9);
        sel_hi <= 1'b1;
        repeat (6) @(posedge pclk);
        rd("limit host", 12'h004, 32'h17);
        apb(1'b1, 12'h000, 32'hB);
        repeat (6) @(posedge pclk);
        rd("ctrl detect clear", 12'h000, 32'h9);
        rd("limit forced", 12'h004, 32'h4);
        apb(1'b1, 12'h004, 32'h9);
        repeat (3) @(posedge pclk);
        chk("iin limit", 32'h9, 32'(pwr.iin_limit));
        sys_low <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("low sys cap", 32'h1, 32'(pwr.iin_limit));
        sys_low <= 1'b0;
        plugged <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0);
        chk("status off", 32'h100, d & 32'h3F03);
        chk("battery again", 32'h1, 32'(pwr.battery_switch));
        ocp <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("switch opened", 32'h0, 32'(pwr.battery_switch));
        rd("ctrl force off", 12'h000, 32'hD);
        ocp     <= 1'b0;
        bad     <= 1'b1;
        plugged <= 1'b1;
        repeat (50) @(posedge pclk);
        rd("status retry", 12'h00C, 32'h800);
        bad <= 1'b0;
        wait_conv(120);
        rd("ctrl after input", 12'h000, 32'h9);
        chk("switch charging", 32'h1, 32'(pwr.battery_switch));
        apb(1'b1, 12'h000, 32'h1);
        repeat (6) @(posedge pclk);
        chk("switch idle", 32'h0, 32'(pwr.battery_switch));
        wrap_up();
    end
endmodule : input_powerup_sequencer_bench

// [tb/ips_seq_asserts.sv]
`timescale 1ns/1ns
module ips_seq_asserts
    import ips_pkg::*;
#(
    parameter logic [24:0] HOLD_CYC  = 25'h14,
    parameter logic [24:0] TEST_CYC  = 25'h0A,
    parameter logic [24:0] RETRY_CYC = 25'h1E
) (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Power side
    input wire ips_pins_t   pins,
    input wire ips_power_t  pwr,
    input wire logic        host_alert_pin_n
);
    // ==================================================
    // Helper counters
    // ==================================================
    logic [24:0] hold_q;
    logic [1:0]  up_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 25'h0;
            up_q   <= 2'h0;
        end else begin
            hold_q <= (pins.vac_present && pins.vac_above_bat) ? hold_q + 25'h1 : 25'h0;
            up_q   <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence low_sys_s;
        pins.sys_below_2v2 [*5];
    endsequence
    sequence no_input_s;
        !pins.vac_present [*5];
    endsequence
    ldo_hold_a: assert property ($rose(pwr.internal_ldo) |-> hold_q >= HOLD_CYC)
        else $error("regulator enabled before the input hold ran out");
    ldo_off_a: assert property (no_input_s |-> !pwr.internal_ldo && !pwr.converter_en)
        else $error("regulator or converter on without input");
    load_ldo_a: assert property (pwr.test_load |-> pwr.internal_ldo)
        else $error("test load applied with regulator off");
    conv_start_a: assert property ($rose(pwr.converter_en) |-> !pwr.test_load)
        else $error("converter started during source test");
    alert_ldo_a: assert property (!host_alert_pin_n |-> pwr.internal_ldo)
        else $error("alert pulse outside powered sequence");
    cap_low_a: assert property (low_sys_s ##0 pwr.converter_en |-> pwr.iin_limit <= 5'h01)
        else $error("input current not capped at low system voltage");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("bus access not answered");
    bad_addr_a: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access without error");
    armed_a: assert property (up_q == 2'h3 |-> pwr.comparators_armed)
        else $error("comparators not armed after reset");
endmodule : ips_seq_asserts

bind ips_sequencer ips_seq_asserts #(.HOLD_CYC(HOLD_CYC), .TEST_CYC(TEST_CYC),
    .RETRY_CYC(RETRY_CYC)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .pwr(pwr),
    .host_alert_pin_n(host_alert_pin_n));

// [tb/ips_src_model.sv]
`timescale 1ns/1ns
module ips_src_model
    import ips_pkg::*;
(
    // Scenario controls
    input wire logic plugged,
    input wire logic bad,
    input wire logic sel_hi,
    input wire logic ocp,
    input wire logic sys_low,
    // Comparator and pin levels
    output ips_pins_t pins
);
    // ==================================================
    // Source and battery levels
    // ==================================================
    always_comb begin
        pins                = '0;
        pins.vac_present    = plugged;
        pins.vac_above_bat  = plugged;
        pins.vbus_ov        = plugged && bad;
        pins.vbus_above_min = plugged;
        pins.bat_above_depl = 1'b1;
        pins.bat_ocp        = ocp;
        pins.sys_below_2v2  = sys_low;
        pins.psel           = sel_hi;
    end
endmodule : ips_src_model
